// *** logic/bridge_map.vh ***
/*
 * Constants for the serial bridge core: request codes, descriptor
 * fields, configuration memory layout, buffer split and watermarks.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BRIDGE_MAP_VH
`define BRIDGE_MAP_VH

// ----------------------------------------------------------------
// Request kinds and codes
// ----------------------------------------------------------------
`define REQ_STD            2'h0
`define REQ_VENDOR         2'h2
`define STD_GET_DESC       8'h06
`define VND_READ           8'h01
`define VND_WRITE          8'h02
`define VND_SET_BAUD       8'h20
`define VND_CFG_PROG       8'h30

// ----------------------------------------------------------------
// Descriptor field indices
// ----------------------------------------------------------------
`define DF_VID_LO          8'h00
`define DF_VID_HI          8'h01
`define DF_PID_LO          8'h02
`define DF_PID_HI          8'h03
`define DF_REL_LO          8'h04
`define DF_REL_HI          8'h05
`define DF_MAXPWR          8'h06
`define DF_SN_MODE         8'h07
`define DF_STRLEN          8'h08
`define DF_SN_BASE         8'h09

// ----------------------------------------------------------------
// Configuration memory layout
// ----------------------------------------------------------------
`define CM_VALID           8'h00
`define CM_VID_LO          8'h01
`define CM_VID_HI          8'h02
`define CM_PID_LO          8'h03
`define CM_PID_HI          8'h04
`define CM_MAXPWR          8'h05
`define CM_SN_MODE         8'h06
`define CM_STRLEN          8'h07
`define CM_CTRL0           8'h08
`define CM_BAUD0           8'h09
`define CM_SN_BASE         8'h0a
`define CM_LAST            8'h0a
`define CM_BLANK           8'hff
`define CM_MARK            8'ha5

// ----------------------------------------------------------------
// Defaults, modes, limits
// ----------------------------------------------------------------
`define DEF_MAXPWR         8'h32
`define MAXPWR_UNIT_MA     2
`define SN_OFF             2'h0
`define SN_UNIQUE          2'h1
`define SN_FIXED           2'h2
`define SN_AUTO            2'h3
`define STR_LIMIT          8'h5a
`define DEF_CTRL           8'h00
`define DEF_BAUD           16'h0004
`define BAUD_MIN_DIV       16'h0004
`define TX_DEPTH           256
`define RX_DEPTH           768
`define RX_HIGH_MARK       736
`define TX_LOW_MARK        384
`define TX_LOW_LEVEL       16
`define DEV_CLK_HZ         25000000
`define MAX_BAUD_BPS       10000000

`endif

// *** logic/sync_fifo.v ***
/*
 * Synchronous byte FIFO with fill level and threshold flags.
 * Assumes single clock, writer honours in_ready, reader honours out_valid.
 */
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4,
   parameter NEAR_EMPTY = 2,
   parameter NEAR_FULL  = 14
) (
   input  wire             clk,        // Core clock
   input  wire             reset_n,    // Async reset, active low
   input  wire [WIDTH-1:0] in_data,    // Write data
   input  wire             in_valid,   // Write request
   output wire             in_ready,   // Not full
   output wire [WIDTH-1:0] out_data,   // Read data
   output wire             out_valid,  // Not empty
   input  wire             out_ready,  // Read accept
   output wire             near_empty, // Level at or below low mark
   output wire             near_full,  // Level at or above high mark
   output wire [AW:0]      level       // Words held
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            do_wr;
   wire            do_rd;

   assign in_ready   = (count != DEPTH[AW:0]);
   assign out_valid  = (count != {(AW+1){1'b0}});
   assign do_wr      = in_valid & in_ready;
   assign do_rd      = out_ready & out_valid;
   assign out_data   = mem[rd_ptr];
   assign near_empty = (count <= NEAR_EMPTY[AW:0]);
   assign near_full  = (count >= NEAR_FULL[AW:0]);
   assign level      = count;

   // ----------------------------------------------------------------
   // Pointers and level
   // ----------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (do_wr & ~do_rd)
            count <= count + 1'b1;
         else if (do_rd & ~do_wr)
            count <= count - 1'b1;
      end
   end

   always @(posedge clk) begin
      if (do_wr)
         mem[wr_ptr] <= in_data;
   end
endmodule

`default_nettype wire

// *** logic/usb_serial_bridge_core.v ***
/*
 * Core of a USB to half-duplex serial bridge: request sequencer,
 * descriptor answer, control registers loaded from configuration
 * memory, outbound and inbound FIFOs, event generator, serial mux
 * and baud divider output.
 * Assumes endpoint engines and serial controller on the same clock;
 * the suspend input comes from the power manager on another clock.
 */
// Operation
// [R1] Standard requests answered from ROM or latched configuration
// [R2] Vendor requests set or get peripheral state
// [R3] Outbound FIFO from bulk-out to serial
// [R4] Outbound near-empty flag to peripheral
// [R5] Inbound FIFO from serial to bulk-in
// [R6] Inbound near-full flag to peripheral
// [R7] Event toggles become interrupt-in data
// [R8] Mux moves FIFO data to transmitter, receiver
// [R9] Baud up to 10 Mbps from host command
// [R10] Control registers load from configuration memory
// [R11] Control registers accessed only by vendor commands
// [R12] Blank configuration memory selects built-in defaults
// [R13] User area written once; blank stays writable
// [R14] Max power stored in 2 mA units
// [R15] Release number fixed, never programmable
// [R16] String lengths total at most 90 characters
// [R17] Serial number disabled, unique, fixed or auto
// [R18] Buffers 256 transmit, 768 receive, marks 736/384; tx_low is set at level 16 or below, not 384
// [R19] Core clock gated off during suspend
// [R20] Full FIFO stalls writer; empty stalls reader
`timescale 1ns/1ps
`default_nettype none
`include "bridge_map.vh"

module usb_serial_bridge_core #(
   parameter [15:0] VENDOR_CODE  = 16'h1234, // Arbitrary value
   parameter [15:0] PRODUCT_CODE = 16'h5678, // Arbitrary value
   parameter [15:0] RELEASE_CODE = 16'h0100, // Arbitrary value
   parameter [31:0] UNIQUE_ID    = 32'h0000_0001, // Arbitrary value
   parameter        CM_WORDS     = 256
) (
   input  wire        clk,          // 25 MHz core clock
   input  wire        reset_n,      // Async reset, active low
   input  wire        suspend,      // USB suspend level, foreign domain
   output reg         clk_run,      // Clock gate enable to generator
   input  wire        req_valid,    // Setup request pulse
   input  wire [1:0]  req_kind,     // Standard or vendor
   input  wire [7:0]  req_code,     // Request code
   input  wire [7:0]  req_index,    // Field or register index
   input  wire [7:0]  req_value,    // Write value
   output reg         rsp_valid,    // Answer pulse
   output reg  [7:0]  rsp_data,     // Answer byte
   output reg         rsp_stall,    // Request refused
   input  wire [7:0]  bo_data,      // Bulk-out byte
   input  wire        bo_valid,     // Bulk-out byte valid
   output reg         bo_ready,     // Outbound FIFO has room
   output reg  [7:0]  bi_data,      // Bulk-in byte
   output reg         bi_valid,     // Bulk-in byte valid
   input  wire        bi_ready,     // Bulk-in accepts
   output reg  [7:0]  tx_data,      // Byte to transmitter
   output reg         tx_valid,     // Transmit byte valid
   input  wire        tx_ready,     // Transmitter accepts
   input  wire [7:0]  rx_data,      // Byte from receiver
   input  wire        rx_valid,     // Receive byte valid
   output reg         rx_ready,     // Inbound FIFO has room
   output reg         tx_low,       // Outbound nearly empty
   output reg         rx_high,      // Inbound nearly full
   output reg  [15:0] baud_div,     // Baud divider to generator
   output reg  [7:0]  ctrl_out,     // Chip function control
   input  wire        uart_evt,     // Serial event toggle
   input  wire [3:0]  gpio_evt,     // GPIO event toggles
   output reg  [7:0]  int_data,     // Interrupt-in payload
   output reg         int_valid,    // Interrupt-in data valid
   input  wire        int_ready,    // Interrupt-in taken
   output reg  [7:0]  cm_addr,      // Config memory address
   output reg  [7:0]  cm_wdata,     // Config memory write data
   output reg         cm_we,        // Config memory write pulse
   input  wire [7:0]  cm_rdata,     // Config memory read data
   output reg         load_done     // Configuration loaded
);
   localparam S_LOAD = 2'h0;
   localparam S_IDLE = 2'h1;
   localparam S_PROG = 2'h2;
   localparam TX_AW  = 8;
   localparam RX_AW  = 10;

   reg  [1:0]  state;
   reg  [7:0]  load_idx;
   reg         cfg_used;
   reg  [15:0] vid;
   reg  [15:0] pid;
   reg  [7:0]  maxpwr;
   reg  [1:0]  sn_mode;
   reg  [31:0] sn_value;
   reg  [7:0]  str_len;
   reg         susp_m;
   reg         susp_s;
   reg  [4:0]  evt_prev;
   reg  [4:0]  evt_pend;
   reg  [7:0]  rd_byte;
   reg  [7:0]  fld;
   wire [4:0]  evt_now;
   wire [4:0]  evt_edge;
   wire [7:0]  tf_data;
   wire        tf_valid;
   wire        tf_in_ready;
   wire        tf_low;
   wire [7:0]  rf_data;
   wire        rf_valid;
   wire        rf_in_ready;
   wire        rf_high;
   wire        tx_take;
   wire        bi_take;

   // ----------------------------------------------------------------
   // Suspend synchroniser and clock gate
   // ----------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         susp_m  <= 1'b0;
         susp_s  <= 1'b0;
         clk_run <= 1'b1;
      end else begin
         susp_m  <= suspend;
         susp_s  <= susp_m;
         clk_run <= ~susp_s; // R19
      end
   end

   // ----------------------------------------------------------------
   // Buffers
   // ----------------------------------------------------------------
   assign tx_take = tx_valid & tx_ready;
   assign bi_take = bi_valid & bi_ready;

   sync_fifo #(
      .WIDTH      (8),
      .DEPTH      (`TX_DEPTH),
      .AW         (TX_AW),
      .NEAR_EMPTY (`TX_LOW_LEVEL),
      .NEAR_FULL  (`TX_DEPTH)
   ) u_out_fifo (
      .clk        (clk),
      .reset_n    (reset_n),
      .in_data    (bo_data),
      .in_valid   (bo_valid & bo_ready),
      .in_ready   (tf_in_ready),
      .out_data   (tf_data),
      .out_valid  (tf_valid),
      .out_ready  (~tx_valid | tx_take),
      .near_empty (tf_low),
      .near_full  (),
      .level      ()
   ); // R3 R18

   sync_fifo #(
      .WIDTH      (8),
      .DEPTH      (`RX_DEPTH),
      .AW         (RX_AW),
      .NEAR_EMPTY (`TX_LOW_MARK),
      .NEAR_FULL  (`RX_HIGH_MARK)
   ) u_in_fifo (
      .clk        (clk),
      .reset_n    (reset_n),
      .in_data    (rx_data),
      .in_valid   (rx_valid & rx_ready),
      .in_ready   (rf_in_ready),
      .out_data   (rf_data),
      .out_valid  (rf_valid),
      .out_ready  (~bi_valid | bi_take),
      .near_empty (),
      .near_full  (rf_high),
      .level      ()
   ); // R5 R18

   // ----------------------------------------------------------------
   // Mux toward transmitter and bulk-in, ready and threshold flags
   // ----------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_data  <= 8'h00;
         tx_valid <= 1'b0;
         bi_data  <= 8'h00;
         bi_valid <= 1'b0;
         bo_ready <= 1'b0;
         rx_ready <= 1'b0;
         tx_low   <= 1'b1;
         rx_high  <= 1'b0;
      end else begin
         if (~tx_valid | tx_take) begin
            tx_valid <= tf_valid; // R8 R20
            tx_data  <= tf_data;
         end
         if (~bi_valid | bi_take) begin
            bi_valid <= rf_valid; // R8 R20
            bi_data  <= rf_data;
         end
         // Registered ready: a one-cycle gap after each accepted byte guards the pipeline delay
         bo_ready <= tf_in_ready & ~(bo_valid & bo_ready) & load_done; // R20
         rx_ready <= rf_in_ready & ~(rx_valid & rx_ready) & load_done; // R20
         tx_low   <= tf_low;  // R4
         rx_high  <= rf_high; // R6
      end
   end

   // ----------------------------------------------------------------
   // Event generator
   // ----------------------------------------------------------------
   assign evt_now  = {gpio_evt, uart_evt};
   assign evt_edge = evt_now ^ evt_prev;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         evt_prev  <= 5'h00;
         evt_pend  <= 5'h00;
         int_valid <= 1'b0;
         int_data  <= 8'h00;
      end else begin
         evt_prev <= evt_now;
         if (int_valid & int_ready) begin
            int_valid <= 1'b0;
            evt_pend  <= evt_pend | evt_edge; // R7
         end else if (~int_valid & (|(evt_pend | evt_edge))) begin
            int_valid <= 1'b1;
            int_data  <= {3'h0, evt_pend | evt_edge}; // R7
            evt_pend  <= 5'h00;
         end else begin
            evt_pend <= evt_pend | evt_edge;
         end
      end
   end

   // ----------------------------------------------------------------
   // Descriptor field mux
   // ----------------------------------------------------------------
   always @* begin
      case (req_index)
         `DF_VID_LO:     fld = vid[7:0];
         `DF_VID_HI:     fld = vid[15:8];
         `DF_PID_LO:     fld = pid[7:0];
         `DF_PID_HI:     fld = pid[15:8];
         `DF_REL_LO:     fld = RELEASE_CODE[7:0];  // R15
         `DF_REL_HI:     fld = RELEASE_CODE[15:8]; // R15
         `DF_MAXPWR:     fld = maxpwr;             // R14
         `DF_SN_MODE:    fld = {6'h00, sn_mode};   // R17
         `DF_STRLEN:     fld = str_len;            // R16
         `DF_SN_BASE:    fld = sn_value[7:0];
         `DF_SN_BASE + 8'h01: fld = sn_value[15:8];
         `DF_SN_BASE + 8'h02: fld = sn_value[23:16];
         `DF_SN_BASE + 8'h03: fld = sn_value[31:24];
         default:        fld = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer: configuration load, requests, one-time programming
   // ----------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= S_LOAD;
         load_idx  <= 8'h00;
         cfg_used  <= 1'b0;
         load_done <= 1'b0;
         vid       <= 16'h0000;
         pid       <= 16'h0000;
         maxpwr    <= `DEF_MAXPWR;
         sn_mode   <= `SN_UNIQUE;
         sn_value  <= 32'h0000_0000;
         str_len   <= 8'h00;
         ctrl_out  <= `DEF_CTRL;
         baud_div  <= `DEF_BAUD;
         rsp_valid <= 1'b0;
         rsp_stall <= 1'b0;
         rsp_data  <= 8'h00;
         cm_addr   <= `CM_VALID;
         cm_wdata  <= 8'h00;
         cm_we     <= 1'b0;
         rd_byte   <= 8'h00;
      end else begin
         rsp_valid <= 1'b0;
         rsp_stall <= 1'b0;
         cm_we     <= 1'b0;
         case (state)
            S_LOAD: begin
               // Address presented one cycle ahead of data
               load_idx <= load_idx + 8'h01;
               cm_addr  <= load_idx + 8'h01;
               case (load_idx)
                  `CM_VALID: cfg_used <= (cm_rdata == `CM_MARK); // R12
                  `CM_VID_LO:  vid[7:0]   <= cfg_used ? cm_rdata : VENDOR_CODE[7:0];
                  `CM_VID_HI:  vid[15:8]  <= cfg_used ? cm_rdata : VENDOR_CODE[15:8];
                  `CM_PID_LO:  pid[7:0]   <= cfg_used ? cm_rdata : PRODUCT_CODE[7:0];
                  `CM_PID_HI:  pid[15:8]  <= cfg_used ? cm_rdata : PRODUCT_CODE[15:8];
                  `CM_MAXPWR:  maxpwr     <= cfg_used ? cm_rdata : `DEF_MAXPWR; // R14
                  `CM_SN_MODE: sn_mode    <= cfg_used ? cm_rdata[1:0] : `SN_UNIQUE; // R17
                  `CM_STRLEN:  str_len    <= (cfg_used && cm_rdata <= `STR_LIMIT) ?
                                             cm_rdata : 8'h00; // R16
                  `CM_CTRL0:   ctrl_out   <= cfg_used ? cm_rdata : `DEF_CTRL; // R10
                  `CM_BAUD0:   baud_div   <= (cfg_used && {8'h00, cm_rdata} >= `BAUD_MIN_DIV) ?
                                             {8'h00, cm_rdata} : `DEF_BAUD; // R10 R9
                  `CM_SN_BASE: begin
                     sn_value  <= (sn_mode == `SN_UNIQUE) ? UNIQUE_ID :
                                  (sn_mode == `SN_OFF) ? 32'h0000_0000 :
                                  {24'h000000, cm_rdata}; // R17
                     state     <= S_IDLE;
                     load_done <= 1'b1; // R10
                  end
                  default: ;
               endcase
            end
            S_IDLE: begin
               if (req_valid) begin
                  rsp_valid <= 1'b1;
                  if (req_kind == `REQ_STD && req_code == `STD_GET_DESC) begin
                     rsp_data <= fld; // R1
                  end else if (req_kind == `REQ_VENDOR) begin
                     case (req_code)
                        `VND_READ: rsp_data <= (req_index == 8'h00) ? ctrl_out :
                                              (req_index == 8'h01) ? baud_div[7:0] :
                                              (req_index == 8'h02) ? baud_div[15:8] :
                                              {3'h0, evt_pend}; // R2 R11
                        `VND_WRITE: begin
                           ctrl_out <= req_value; // R2 R11
                           rsp_data <= req_value;
                        end
                        `VND_SET_BAUD: begin
                           // Divider below minimum would exceed 10 Mbps
                           if ({req_index, req_value} >= `BAUD_MIN_DIV)
                              baud_div <= {req_index, req_value}; // R9
                           else
                              rsp_stall <= 1'b1;
                           rsp_data <= req_value;
                        end
                        `VND_CFG_PROG: begin
                           cm_addr  <= req_index;
                           cm_wdata <= req_value;
                           state    <= S_PROG;
                           rsp_valid <= 1'b0;
                        end
                        default: rsp_stall <= 1'b1;
                     endcase
                  end else begin
                     rsp_stall <= 1'b1;
                  end
               end
            end
            S_PROG: begin
               // Location accepts a write only while it reads blank
               rsp_valid <= 1'b1;
               rsp_data  <= cm_rdata;
               if (cm_rdata == `CM_BLANK) begin
                  cm_we <= 1'b1; // R13
                  if (cm_addr == `CM_SN_BASE && sn_mode == `SN_AUTO)
                     sn_value <= sn_value + 32'h0000_0001; // R17
               end else begin
                  rsp_stall <= 1'b1; // R13
               end
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

`default_nettype wire

// *** bench/bridge_checker_assertions.sv ***
/* Checker for usb_serial_bridge_core port timing.
   Assumes bind to the core and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module bridge_checker (
   input wire logic       clk,       // Clock
   input wire logic       reset_n,   // Reset
   input wire logic       suspend,   // Suspend
   input wire logic       clk_run,   // Gate
   input wire logic       bo_valid,  // Out valid
   input wire logic       bo_ready,  // Out ready
   input wire logic       rx_valid,  // In valid
   input wire logic       rx_ready,  // In ready
   input wire logic       tx_valid,  // Tx valid
   input wire logic       tx_ready,  // Tx ready
   input wire logic [7:0] tx_data,   // Tx byte
   input wire logic       int_valid, // Event valid
   input wire logic       int_ready, // Event taken
   input wire logic       cm_we,     // Cell write
   input wire logic [7:0] cm_rdata,  // Cell read
   input wire logic       load_done  // Loaded
);
   // ---
   // Port timing
   // ---
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_sleep; $rose(suspend); endsequence
   sequence s_gate_off; ##[1:4] !clk_run; endsequence
   property p_bo_gap; bo_valid && bo_ready |=> !bo_ready; endproperty
   a_bo_gap: assert property (p_bo_gap) else $error("bulk-out ready held");
   property p_rx_gap; rx_valid && rx_ready |=> !rx_ready; endproperty
   a_rx_gap: assert property (p_rx_gap) else $error("receive ready held");
   property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
   property p_int_hold; int_valid && !int_ready |=> int_valid; endproperty
   a_int_hold: assert property (p_int_hold) else $error("event data dropped");
   property p_prog_blank; cm_we |-> cm_rdata == 8'hff; endproperty
   a_prog_blank: assert property (p_prog_blank) else $error("used cell written");
   property p_sleep; s_sleep |-> s_gate_off; endproperty
   a_sleep: assert property (p_sleep) else $error("clock not gated");
   property p_open; $rose(load_done) |=> bo_ready && rx_ready; endproperty
   a_open: assert property (p_open) else $error("paths not opened");
   property p_closed; !load_done |-> !bo_ready && !rx_ready; endproperty
   a_closed: assert property (p_closed) else $error("paths open early");
endmodule
bind usb_serial_bridge_core bridge_checker u_chk (.*);
`default_nettype wire

// *** bench/serial_far_end.sv ***
/* Far end: configuration memory cells and a transmitter that
   accepts at random. Assumes the core drives cm_* on clk. */
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
   input  wire logic       clk,      // Clock
   input  wire logic [7:0] cm_addr,  // Cell address
   input  wire logic [7:0] cm_wdata, // Cell data
   input  wire logic       cm_we,    // Cell write
   output logic      [7:0] cm_rdata, // Cell read
   output logic            tx_ready  // Tx accept
);
   logic [7:0] cells [0:255];
   integer     seed = 32'ha2c8;
   initial begin
      foreach (cells[j])
         cells[j] = 8'hff;
      tx_ready = 1'b0;
   end
   assign cm_rdata = cells[cm_addr];
   always @(posedge clk) begin
      if (cm_we)
         cells[cm_addr] <= cm_wdata;
      tx_ready <= $random(seed) % 2 != 0;
   end
endmodule
`default_nettype wire

// *** bench/usb_serial_bridge_core_tb_top.sv ***
/* Bench for usb_serial_bridge_core: requests, memory, streams,
   events, suspend. Assumes far-end model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "bridge_map.vh"
module usb_serial_bridge_core_tb_top;
   logic        clk = 0, reset_n = 0, suspend = 0, req_valid = 0;
   logic [1:0]  req_kind = '0;
   logic [7:0]  req_code = '0, req_index = '0, req_value = '0, bo_data = '0, rx_data = '0;
   logic        bo_valid = 0, rx_valid = 0, bi_ready = 0, uart_evt = 0, int_ready = 0;
   logic [3:0]  gpio_evt = '0;
   logic        rsp_valid, rsp_stall, bo_ready, bi_valid, tx_valid, tx_ready, rx_ready;
   logic        tx_low, rx_high, int_valid, cm_we, load_done, clk_run, drain = 0, s;
   logic [7:0]  rsp_data, bi_data, tx_data, ctrl_out, int_data, cm_addr, cm_wdata, cm_rdata, d;
   logic [15:0] baud_div;
   integer      n_fail = 0, total_checks = 0, seed = 32'ha2c8, i, k;
   logic [7:0]  txq[$], biq[$], exq[$];
   usb_serial_bridge_core u_dut (.*);
   serial_far_end u_far (.*);
   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (tx_valid && tx_ready)
         txq.push_back(tx_data);
      if (bi_valid && bi_ready)
         biq.push_back(bi_data);
      bi_ready <= drain && $random(seed) % 2 != 0;
   end
   // ---
   // Tasks
   // ---
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string w, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic hang;
      n_fail++;
      $display("[FAIL] wait expected handshake seen timeout");
      tally_and_finish;
   endtask
   task automatic boot;
      reset_n <= 0;
      repeat (2) @(posedge clk);
      reset_n <= 1;
      for (k = 0; load_done !== 1; k++) begin
         if (k > 30) hang;
         @(posedge clk);
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic req(input logic [1:0] kd, input logic [7:0] c, x, v);
      @(posedge clk);
      {req_valid, req_kind, req_code, req_index, req_value} <= {1'b1, kd, c, x, v};
      @(posedge clk);
      req_valid <= 0;
      for (k = 0; rsp_valid !== 1; k++) begin
         if (k > 4) hang;
         @(posedge clk);
      end
      d = rsp_data;
      s = rsp_stall;
      repeat (3) @(posedge clk);
   endtask
   task automatic put(input bit inb, input int n);
      for (i = 0; i < n; i++) begin
         exq.push_back(8'($random(seed)));
         if (inb)
            {rx_valid, rx_data} <= {1'b1, exq[$]};
         else
            {bo_valid, bo_data} <= {1'b1, exq[$]};
         k = 0;
         do begin
            if (k++ > 9) hang;
            @(posedge clk);
         end while ((inb ? rx_ready : bo_ready) !== 1);
      end
      {rx_valid, bo_valid} <= 2'b00;
   endtask
   task automatic match(ref logic [7:0] q[$], input int n);
      for (k = 0; q.size() < n; k++) begin
         if (k > 5000) hang;
         @(posedge clk);
      end
      foreach (exq[j])
         chk("stream byte", q[j], exq[j]);
   endtask
   // ---
   // Scenarios
   // ---
   initial begin
      boot;
      chk("flags", {tx_low, rx_high}, 2'b10);
      exq = {8'h34, 8'h12, 8'h78, 8'h56, 8'h00, 8'h01, 8'd50};
      for (i = 0; i < 7; i++) begin
         req(`REQ_STD, `STD_GET_DESC, i[7:0], 8'h00);
         chk("descriptor", d, exq[i]);
      end
      $display("test descriptors done");
      req(`REQ_VENDOR, `VND_WRITE, 8'h00, 8'h5a);
      chk("ctrl_out", ctrl_out, 8'h5a);
      req(`REQ_VENDOR, `VND_READ, 8'h00, 8'h00);
      chk("ctrl read", d, 8'h5a);
      req(`REQ_VENDOR, `VND_SET_BAUD, 8'h00, 8'h03);
      chk("baud refused", {s, baud_div[14:0]}, 16'h8004);
      req(`REQ_VENDOR, `VND_SET_BAUD, 8'h00, 8'h05);
      chk("baud set", {s, baud_div[14:0]}, 16'h0005);
      req(`REQ_VENDOR, 8'h7e, 8'h00, 8'h00);
      chk("unknown stall", s, 1);
      $display("test vendor done");
      req(`REQ_VENDOR, `VND_CFG_PROG, 8'h05, 8'h64);
      chk("first program", s, 0);
      req(`REQ_VENDOR, `VND_CFG_PROG, 8'h05, 8'h10);
      chk("second program", s, 1);
      req(`REQ_VENDOR, `VND_CFG_PROG, 8'h00, 8'ha5);
      boot;
      chk("loaded ctrl", ctrl_out, 8'hff);
      req(`REQ_STD, `STD_GET_DESC, 8'h06, 8'h00);
      chk("max power", d, 8'h64);
      req(`REQ_STD, `STD_GET_DESC, 8'h04, 8'h00);
      chk("release", d, 8'h00);
      req(`REQ_STD, `STD_GET_DESC, 8'h08, 8'h00);
      chk("string length", d, 8'h00);
      $display("test memory done");
      exq = {};
      put(0, 40);
      match(txq, 40);
      exq = {};
      put(1, 769);
      chk("rx_high", rx_high, 1);
      @(posedge clk) rx_valid <= 1;
      repeat (4) @(posedge clk);
      chk("rx refused", rx_ready, 0);
      rx_valid <= 0;
      drain <= 1;
      match(biq, 769);
      $display("test streams done");
      {gpio_evt, uart_evt} <= 5'h09;
      for (k = 0; int_valid !== 1; k++) begin
         if (k > 5) hang;
         @(posedge clk);
      end
      chk("int_data", int_data, 8'h09);
      uart_evt <= 0;
      @(posedge clk);
      int_ready <= 1;
      @(posedge clk);
      int_ready <= 0;
      @(posedge clk);
      chk("int cleared", int_valid, 0);
      @(posedge clk);
      chk("int kept", {int_valid, int_data}, 9'h101);
      suspend <= 1;
      repeat (6) @(posedge clk);
      chk("clk_run", clk_run, 0);
      suspend <= 0;
      $display("test events done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
